// file: bench/twd_top_test.sv
// Self-checking bench for the timer and watchdog block
`timescale 1ns/1ps
module twd_top_test;
    import twd_pkg::*;

    // Short slow tick keeps every count small enough to walk through
    localparam int unsigned SDIV = 8;

    logic        clk;
    logic        arst_n;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        debug_freeze;
    logic        timer_irq;
    logic        timer_underflow_pulse;
    logic        watchdog_reset_req;
    logic [31:0] rd;
    logic [3:0]  sel_v;
    logic        ien;
    int          fail_count;
    int          n_checks;
    int          per;
    int          rl;
    int          cnt;
    int          exp_per;

    twd_top #(.SLOW_DIV(SDIV)) DUT (
        .clk                   (clk),
        .arst_n                (arst_n),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .debug_freeze          (debug_freeze),
        .timer_irq             (timer_irq),
        .timer_underflow_pulse (timer_underflow_pulse),
        .watchdog_reset_req    (watchdog_reset_req)
    );

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run, shared by the main sequence and the hang guard
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_sig(input logic got, input logic exp, input string s);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s is %b expected %b", $time, s, got, exp);
        end
    endtask : chk_sig

    task automatic chk_num(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] %0t period %0d expected %0d", $time, got, exp);
        end
    endtask : chk_num

    // One classic cycle; held until ack is sampled high, then released
    task automatic wb(input logic we, input logic [4:0] adr,
                      input logic [31:0] dat);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel_v;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) begin
            fail_count++;
            $display("[FAIL] %0t bus cycle never acknowledged", $time);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic rdreg(input logic [4:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk_reg(rd, exp);
    endtask : rdreg

    // Counts cycles up to the next underflow pulse, bounded by lim
    task automatic wait_pulse(input int lim);
        per = 0;
        do begin
            @(posedge clk);
            per++;
        end while (timer_underflow_pulse !== 1'b1 && per < lim);
    endtask : wait_pulse

    task automatic wait_err(input int lim);
        int n;
        n = 0;
        while (watchdog_reset_req !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk_sig(watchdog_reset_req, 1'b1, "watchdog reset request");
    endtask : wait_err

    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
    endtask : do_reset

    // Fast timer (16 cycles), then watchdog in match mode with count 6
    task automatic wd_setup;
        wb(1'b1, ADR_RLD, 32'h1);
        wb(1'b1, ADR_CSR, 32'h1);
        wb(1'b1, ADR_CFG, 32'h30);
        wb(1'b1, ADR_WDC, 32'h6);
        repeat (20) @(posedge clk);
    endtask : wd_setup

    // Hang guard, well beyond the expected length of the run
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        summarize();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 5'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        debug_freeze = 1'b0;
        sel_v = 4'hf;
        fail_count = 0;
        n_checks = 0;
        void'($urandom(78425));
        do_reset();
        // Reset values, write-only and unmapped places, lane-less write
        rdreg(ADR_CFG, 32'h0);
        rdreg(ADR_PRE, 32'h0);
        rdreg(ADR_RLD, 32'h0000ffff);
        rdreg(ADR_CSR, 32'h0);
        rdreg(ADR_WDC, 32'h0);
        wb(1'b1, 5'h18, 32'hff);
        rdreg(5'h18, 32'h0);
        sel_v = 4'he;
        wb(1'b1, ADR_PRE, 32'h3);
        sel_v = 4'hf;
        rdreg(ADR_PRE, 32'h0);
        // Prescaler codes 0 to 5 with a random legal reload
        for (int c = 0; c < 6; c++) begin
            rl = $urandom_range(7, 1);
            ien = c[0];
            exp_per = (rl + 1) * (1 << c) * SDIV;
            wb(1'b1, ADR_PRE, 32'(c));
            wb(1'b1, ADR_RLD, 32'(rl));
            wb(1'b1, ADR_CSR, 32'({ien, 2'b01}));
            wait_pulse(2 * exp_per + 64);
            wait_pulse(exp_per + 8);
            chk_num(per, exp_per);
            chk_sig(timer_irq, ien, "timer interrupt");
            rdreg(ADR_CSR, 32'({ien, 2'b10}));
            wb(1'b1, ADR_CSR, 32'({ien, 2'b10}));
            rdreg(ADR_CSR, 32'({ien, 2'b00}));
        end
        chk_sig(watchdog_reset_req, 1'b0, "idle watchdog");
        // Freeze with and without the timer freeze enable
        wb(1'b1, ADR_PRE, 32'h0);
        wb(1'b1, ADR_RLD, 32'h3);
        wb(1'b1, ADR_CSR, 32'h1);
        debug_freeze <= 1'b1;
        wait_pulse(200);
        chk_sig(timer_underflow_pulse, 1'b1, "pulse in freeze");
        rdreg(ADR_CSR, 32'h2);
        rdreg(ADR_CSR, 32'h2);
        wb(1'b1, ADR_CSR, 32'h10);
        repeat (4) @(posedge clk);
        wait_pulse(150);
        chk_sig(timer_underflow_pulse, 1'b0, "pulse frozen");
        debug_freeze <= 1'b0;
        wait_pulse(200);
        chk_sig(timer_underflow_pulse, 1'b1, "pulse after freeze");
        // Locks hold settings against later writes until reset
        rl = $urandom_range(5, 1);
        wb(1'b1, ADR_PRE, 32'h2);
        wb(1'b1, ADR_RLD, 32'(rl));
        wb(1'b1, ADR_CSR, 32'h1);
        wb(1'b1, ADR_CFG, 32'h1f);
        wb(1'b1, ADR_PRE, 32'h0);
        wb(1'b1, ADR_RLD, 32'h1);
        wb(1'b1, ADR_CSR, 32'h4);
        wb(1'b1, ADR_CFG, 32'h0);
        wb(1'b1, ADR_WDC, 32'h1);
        rdreg(ADR_CFG, 32'h0);
        rdreg(ADR_RLD, 32'h0);
        exp_per = (rl + 1) * 4 * SDIV;
        wait_pulse(2 * exp_per + 64);
        wait_pulse(exp_per + 8);
        chk_num(per, exp_per);
        chk_sig(timer_irq, 1'b0, "locked interrupt enable");
        chk_sig(watchdog_reset_req, 1'b0, "locked count write");
        do_reset();
        rdreg(ADR_CFG, 32'h0);
        // Count servicing on the time base, then no service until the error
        cnt = $urandom_range(6, 3);
        wb(1'b1, ADR_RLD, 32'h1);
        wb(1'b1, ADR_CSR, 32'h1);
        wb(1'b1, ADR_CFG, 32'h10);
        wait_pulse(64);
        wb(1'b1, ADR_WDC, 32'(cnt));
        rdreg(ADR_CSR, 32'ha);
        // Short gap: a count of 3 runs out four ticks after its load
        repeat (4) @(posedge clk);
        wb(1'b0, ADR_CSR, 32'h0);
        chk_reg(rd & 32'h8, 32'h0);
        for (int i = 0; i < 8; i++) begin
            repeat (12) @(posedge clk);
            wb(1'b1, ADR_WDC, 32'(cnt));
        end
        chk_sig(watchdog_reset_req, 1'b0, "serviced in time");
        repeat (cnt * SDIV) @(posedge clk);
        chk_sig(watchdog_reset_req, 1'b0, "early error");
        wait_err(32);
        // Match servicing: good keys, then two keys in one tick
        do_reset();
        wd_setup();
        for (int i = 0; i < 4; i++) begin
            wait_pulse(40);
            wb(1'b1, ADR_MATCH, 32'(MATCH_KEY));
        end
        chk_sig(watchdog_reset_req, 1'b0, "match service");
        wait_pulse(40);
        wb(1'b1, ADR_MATCH, 32'(MATCH_KEY));
        wb(1'b1, ADR_MATCH, 32'(MATCH_KEY));
        wait_err(40);
        // Wrong key in match mode
        do_reset();
        wd_setup();
        cnt = $urandom_range(255, 0);
        if (cnt == 32'(MATCH_KEY)) begin
            cnt = 8'h5d;
        end
        wait_pulse(40);
        wb(1'b1, ADR_MATCH, 32'(cnt));
        wait_err(40);
        // Count mode on slow underflow clock ignores match writes
        do_reset();
        wb(1'b1, ADR_RLD, 32'h40);
        wb(1'b1, ADR_CSR, 32'h1);
        wb(1'b1, ADR_CFG, 32'h0);
        wb(1'b1, ADR_WDC, 32'h2);
        wb(1'b1, ADR_MATCH, 32'h11);
        repeat (300) @(posedge clk);
        chk_sig(watchdog_reset_req, 1'b0, "underflow clocked");
        wb(1'b1, ADR_CFG, 32'h10);
        wait_err(60);
        summarize();
    end
endmodule : twd_top_test

// file: hw/twd_tick_div.sv
// Enable divider: one pulse for every limit+1 input enables
`timescale 1ns/1ps
module twd_tick_div #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             en,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  tick
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic             tick_r;
    logic             tick_nxt;

    initial begin
        if (WIDTH < 1) $error("twd_tick_div: WIDTH must be at least 1");
    end

    // A shrinking limit below the count wraps at the next enable
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (en) begin
            if (cnt_r >= limit) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : twd_tick_div

// file: hw/twd_top.sv
// Timer and watchdog block with a classic Wishbone slave
//
// Function
// - Locked registers ignore writes; their reads return zero here.
// - Lock bits, once set, stay set until device reset.
// - Config bit0 locks config, bit1 prescaler, bit3 watchdog count.
// - Config bit2 locks timer reload and timer control/status together.
// - Config bit4 picks watchdog clock: 0 timer underflow, 1 time base.
// - Config bit5 picks service: 0 count write only, 1 count or match write of 5Ch.
// - Prescaler codes 0 to 5 divide the slow clock by 1 to 32.
// - Reload register resets to FFFFh and reloads timer on underflow.
// - Restart bit reloads timer at next time-base tick and self-clears.
// - Terminal count set at zero, cleared by status read, write ignored.
// - Status read during debug freeze leaves terminal count set.
// - Interrupt enable gives an interrupt on each timer zero.
// - Status bit3 shows a watchdog write still in transfer.
// - Freeze enable lets freeze stop the timer; watchdog always stops.
// - Watchdog count resets to 0Fh; writes start or restart the count.
// - Timer is a 16-bit down counter reloading at zero.
// - Watchdog is an 8-bit down counter, idle and silent until started.
// - Match write 5Ch reloads; other values or double writes are errors.
// - Any watchdog error requests a device reset.
`timescale 1ns/1ps
module twd_top #(
    parameter int unsigned SLOW_DIV = twd_pkg::SLOW_DIV_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [twd_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      debug_freeze,
    output logic                           timer_irq,
    output logic                           timer_underflow_pulse,
    output logic                           watchdog_reset_req
);
    import twd_pkg::*;

    localparam int unsigned SLOW_W = $clog2(SLOW_DIV + 1);

    initial begin
        if (SLOW_DIV < 1) $error("twd_top: SLOW_DIV must be at least 1");
    end

    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [15:0]      rld_r, rld_nxt;
    logic [15:0]      tmr_r, tmr_nxt;
    logic             rst_bit_r, rst_bit_nxt;
    logic             tc_r, tc_nxt;
    logic             ien_r, ien_nxt;
    logic             frz_en_r, frz_en_nxt;
    logic             und_r, und_nxt;
    logic             irq_r, irq_nxt;
    logic             ack_r, ack_nxt;
    logic [31:0]      dat_r, dat_nxt;

    logic             acc, wr, rd;
    logic             lk_cfg, lk_pre, lk_tmr, lk_wdc;
    logic             slow_tick, tb_tick, wd_tick, adv;
    logic [2:0]       pre_code;
    logic [5:0]       pre_limit;
    logic             wd_pend, wd_err;
    logic             wdc_wr, match_wr;

    // Access completes at the edge where ack is high, so writes and
    // read side effects land on the very edge the master samples ack
    assign acc = wb_cyc_i && wb_stb_i && ack_r;
    assign wr  = acc && wb_we_i && wb_sel_i[0];
    assign rd  = acc && !wb_we_i;

    assign lk_cfg = cfg_r[CFG_LOCK_CFG];
    assign lk_pre = cfg_r[CFG_LOCK_PRE];
    assign lk_tmr = cfg_r[CFG_LOCK_TMR];
    assign lk_wdc = cfg_r[CFG_LOCK_WDC];

    // Slow clock enable, then the programmable time-base divider
    twd_tick_div #(.WIDTH(SLOW_W)) u_slow (
        .clk    (clk),
        .arst_n (arst_n),
        .en     (1'b1),
        .limit  (SLOW_W'(SLOW_DIV - 1)),
        .tick   (slow_tick)
    );

    // Reserved codes are served as the largest divisor
    assign pre_code  = (pre_r > PRE_CODE_MAX) ? PRE_CODE_MAX : pre_r;
    assign pre_limit = (6'h01 << pre_code) - 6'h01;

    twd_tick_div #(.WIDTH(6)) u_pre (
        .clk    (clk),
        .arst_n (arst_n),
        .en     (slow_tick),
        .limit  (pre_limit),
        .tick   (tb_tick)
    );

    // Watchdog clock source and service strobes
    assign wd_tick  = cfg_r[CFG_WD_CLK] ? tb_tick : und_r;
    assign wdc_wr   = wr && wb_adr_i == ADR_WDC && !lk_wdc;
    assign match_wr = wr && wb_adr_i == ADR_MATCH;

    twd_watchdog u_wd (
        .clk       (clk),
        .arst_n    (arst_n),
        .slow_tick (slow_tick),
        .wd_tick   (wd_tick),
        .freeze    (debug_freeze),
        .cnt_wr    (wdc_wr),
        .match_wr  (match_wr),
        .wr_data   (wb_dat_i[7:0]),
        .match_en  (cfg_r[CFG_MATCH_EN]),
        .pending   (wd_pend),
        .wd_error  (wd_err)
    );

    // Configuration and prescaler registers
    always_comb begin
        cfg_nxt = cfg_r;
        pre_nxt = pre_r;
        if (wr && wb_adr_i == ADR_CFG && !lk_cfg) begin
            cfg_nxt = (wb_dat_i[CFG_W-1:0] & ~CFG_LOCK_MASK)
                    | ((wb_dat_i[CFG_W-1:0] | cfg_r) & CFG_LOCK_MASK);
        end
        if (wr && wb_adr_i == ADR_PRE && !lk_pre)
            pre_nxt = wb_dat_i[PRE_W-1:0];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= CFG_RST;
            pre_r <= PRE_RST;
        end else begin
            cfg_r <= cfg_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Periodic timer, its control bits and terminal count
    assign adv = tb_tick && !(debug_freeze && frz_en_r);

    always_comb begin
        rld_nxt     = rld_r;
        tmr_nxt     = tmr_r;
        rst_bit_nxt = rst_bit_r;
        tc_nxt      = tc_r;
        ien_nxt     = ien_r;
        frz_en_nxt  = frz_en_r;
        und_nxt     = 1'b0;
        if (adv) begin
            if (rst_bit_r) begin
                tmr_nxt     = rld_r;
                rst_bit_nxt = 1'b0;
            end else if (tmr_r == 16'h0000) begin
                tmr_nxt = rld_r;
            end else begin
                tmr_nxt = tmr_r - 16'h0001;
                und_nxt = (tmr_r == 16'h0001);
            end
        end
        // Status read clears the flag unless the timer is locked or a debugger holds freeze
        if (rd && wb_adr_i == ADR_CSR && !lk_tmr && !debug_freeze)
            tc_nxt = 1'b0;
        if (und_nxt)
            tc_nxt = 1'b1;
        if (wr && !lk_tmr) begin
            if (wb_adr_i == ADR_RLD) begin
                rld_nxt[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1])
                    rld_nxt[15:8] = wb_dat_i[15:8];
            end
            if (wb_adr_i == ADR_CSR) begin
                if (wb_dat_i[CSR_RESTART])
                    rst_bit_nxt = 1'b1;
                ien_nxt    = wb_dat_i[CSR_IEN];
                frz_en_nxt = wb_dat_i[CSR_FRZ_EN];
            end
        end
        irq_nxt = und_nxt && ien_r;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rld_r     <= RLD_RST;
            tmr_r     <= RLD_RST;
            rst_bit_r <= 1'b0;
            tc_r      <= 1'b0;
            ien_r     <= 1'b0;
            frz_en_r  <= 1'b0;
            und_r     <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            rld_r     <= rld_nxt;
            tmr_r     <= tmr_nxt;
            rst_bit_r <= rst_bit_nxt;
            tc_r      <= tc_nxt;
            ien_r     <= ien_nxt;
            frz_en_r  <= frz_en_nxt;
            und_r     <= und_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // Bus answer: ack one cycle after the request, data with it
    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CFG:
                if (!lk_cfg) dat_nxt = 32'(cfg_r);
            ADR_PRE:
                if (!lk_pre) dat_nxt = 32'(pre_r);
            ADR_RLD:
                if (!lk_tmr) dat_nxt = 32'(rld_r);
            ADR_CSR:
                if (!lk_tmr)
                    dat_nxt = 32'({frz_en_r, wd_pend, ien_r,
                                   tc_r, rst_bit_r});
            default:
                dat_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o              = ack_r;
    assign wb_dat_o              = dat_r;
    assign timer_irq             = irq_r;
    assign timer_underflow_pulse = und_r;
    assign watchdog_reset_req    = wd_err;

    property p_lock_sticky;
        @(posedge clk) disable iff (!arst_n)
        (($past(cfg_r) & ~cfg_r & CFG_LOCK_MASK) == 6'h00);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared");

    property p_pre_locked;
        @(posedge clk) disable iff (!arst_n)
        (wr && wb_adr_i == ADR_PRE && lk_pre) |=> $stable(pre_r);
    endproperty
    a_pre_locked: assert property (p_pre_locked)
        else $error("locked prescaler changed");

    property p_tmr_locked;
        @(posedge clk) disable iff (!arst_n)
        (wr && wb_adr_i == ADR_RLD && lk_tmr) |=> $stable(rld_r);
    endproperty
    a_tmr_locked: assert property (p_tmr_locked)
        else $error("locked reload changed");

    property p_restart;
        @(posedge clk) disable iff (!arst_n)
        (adv && rst_bit_r) |=> !rst_bit_r && tmr_r == $past(rld_r);
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not reload timer");

    property p_tc_set;
        @(posedge clk) disable iff (!arst_n)
        und_r |-> tc_r;
    endproperty
    a_tc_set: assert property (p_tc_set)
        else $error("terminal count not set at zero");

    property p_tc_freeze;
        @(posedge clk) disable iff (!arst_n)
        (tc_r && debug_freeze) |=> tc_r;
    endproperty
    a_tc_freeze: assert property (p_tc_freeze)
        else $error("terminal count cleared under freeze");

    property p_irq;
        @(posedge clk) disable iff (!arst_n)
        irq_r |-> $past(ien_r) && und_r;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enabled zero");

    property p_freeze_tmr;
        @(posedge clk) disable iff (!arst_n)
        (debug_freeze && frz_en_r) |=> $stable(tmr_r);
    endproperty
    a_freeze_tmr: assert property (p_freeze_tmr)
        else $error("timer ran while frozen");

    property p_count_down;
        @(posedge clk) disable iff (!arst_n)
        (adv && !rst_bit_r && tmr_r != 16'h0000)
            |=> tmr_r == $past(tmr_r) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("timer failed to decrement");
endmodule : twd_top

// file: hw/twd_watchdog.sv
// Eight-bit watchdog counter with count and match servicing
`timescale 1ns/1ps
module twd_watchdog
    import twd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       slow_tick,
    input  wire logic       wd_tick,
    input  wire logic       freeze,
    input  wire logic       cnt_wr,
    input  wire logic       match_wr,
    input  wire logic [7:0] wr_data,
    input  wire logic       match_en,
    output logic            pending,
    output logic            wd_error
);
    logic [7:0] rld_r, rld_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic       start_r, start_nxt;
    logic       pend_r, pend_nxt;
    logic       srv_r, srv_nxt;
    logic       err_r, err_nxt;
    logic       mwr;

    assign mwr = match_wr && match_en;

    // Writes reach the counter only on a slow clock tick, like a
    // transfer into the slow domain; pending covers that gap
    always_comb begin
        rld_nxt   = rld_r;
        cnt_nxt   = cnt_r;
        start_nxt = start_r;
        pend_nxt  = pend_r;
        srv_nxt   = srv_r;
        err_nxt   = err_r;
        if (slow_tick && pend_r) begin
            cnt_nxt  = rld_r;
            pend_nxt = 1'b0;
        end else if (start_r && !pend_r && wd_tick && !freeze) begin
            if (cnt_r == 8'h00)
                err_nxt = 1'b1;
            else
                cnt_nxt = cnt_r - 8'h01;
        end
        if (wd_tick && !freeze)
            srv_nxt = 1'b0;
        if (cnt_wr) begin
            rld_nxt   = wr_data;
            start_nxt = 1'b1;
            pend_nxt  = 1'b1;
        end
        if (mwr) begin
            start_nxt = 1'b1;
            if (wr_data != MATCH_KEY || srv_r) begin
                err_nxt = 1'b1;
            end else begin
                pend_nxt = 1'b1;
                srv_nxt  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rld_r   <= WDC_RST;
            cnt_r   <= 8'h00;
            start_r <= 1'b0;
            pend_r  <= 1'b0;
            srv_r   <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            rld_r   <= rld_nxt;
            cnt_r   <= cnt_nxt;
            start_r <= start_nxt;
            pend_r  <= pend_nxt;
            srv_r   <= srv_nxt;
            err_r   <= err_nxt;
        end
    end

    assign pending  = pend_r;
    assign wd_error = err_r;

    property p_wd_quiet;
        @(posedge clk) disable iff (!arst_n)
        !start_r |-> !err_r;
    endproperty
    a_wd_quiet: assert property (p_wd_quiet)
        else $error("watchdog error before start");

    property p_bad_key;
        @(posedge clk) disable iff (!arst_n)
        (mwr && wr_data != MATCH_KEY) |=> err_r;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong match value gave no error");

    property p_err_sticky;
        @(posedge clk) disable iff (!arst_n)
        err_r |=> err_r;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("watchdog error dropped");
endmodule : twd_watchdog

// file: include/twd_pkg.sv
// Shared constants for the timer and watchdog block
package twd_pkg;
    // Clock rates and the slow clock divide derived from them
    localparam int unsigned CLK_FREQ_HZ  = 200_000_000;
    localparam int unsigned SLOW_FREQ_HZ = 32_768;
    localparam int unsigned SLOW_DIV_CYCLES = CLK_FREQ_HZ / SLOW_FREQ_HZ;

    // Byte addresses on the register bus
    localparam int unsigned ADR_W = 5;
    localparam logic [4:0] ADR_CFG   = 5'h00;
    localparam logic [4:0] ADR_PRE   = 5'h04;
    localparam logic [4:0] ADR_RLD   = 5'h08;
    localparam logic [4:0] ADR_CSR   = 5'h0c;
    localparam logic [4:0] ADR_WDC   = 5'h10;
    localparam logic [4:0] ADR_MATCH = 5'h14;

    // Configuration register fields
    localparam int unsigned CFG_W         = 6;
    localparam int unsigned CFG_LOCK_CFG  = 0;
    localparam int unsigned CFG_LOCK_PRE  = 1;
    localparam int unsigned CFG_LOCK_TMR  = 2;
    localparam int unsigned CFG_LOCK_WDC  = 3;
    localparam int unsigned CFG_WD_CLK    = 4;
    localparam int unsigned CFG_MATCH_EN  = 5;
    localparam logic [5:0]  CFG_LOCK_MASK = 6'h0f;
    localparam logic [5:0]  CFG_RST       = 6'h00;

    // Control and status register fields
    localparam int unsigned CSR_RESTART = 0;
    localparam int unsigned CSR_TC      = 1;
    localparam int unsigned CSR_IEN     = 2;
    localparam int unsigned CSR_PEND    = 3;
    localparam int unsigned CSR_FRZ_EN  = 4;

    // Prescaler, reload and watchdog values
    localparam int unsigned PRE_W        = 3;
    localparam logic [2:0]  PRE_RST      = 3'h0;
    localparam logic [2:0]  PRE_CODE_MAX = 3'h5;
    localparam logic [15:0] RLD_RST      = 16'hffff;
    localparam logic [7:0]  WDC_RST      = 8'h0f;
    localparam logic [7:0]  MATCH_KEY    = 8'h5c;
endpackage : twd_pkg
